// *** rtl/rqtx_map.vh ***
/*
  Constants for the requester request transmit adapter: sideband field
  positions, descriptor flag bits, keep codes and credit selection codes.
  Assumes inclusion by bare name from the adapter module.
*/
`ifndef RQTX_MAP_VH
`define RQTX_MAP_VH

// -------------------------------------------------------------------------
// Sideband field positions
// -------------------------------------------------------------------------
`define RQTX_FIRST_DWORD_BYTE_ENABLE_LSB     0
`define RQTX_FIRST_DWORD_BYTE_ENABLE_MSB     3
`define RQTX_LAST_DWORD_BYTE_ENABLE_LSB      4
`define RQTX_LAST_DWORD_BYTE_ENABLE_MSB      7
`define RQTX_DISCONTINUE_BIT  11
`define RQTX_SIDEBAND_W       60

// -------------------------------------------------------------------------
// Descriptor flag bits
// -------------------------------------------------------------------------
`define RQTX_FORCE_ECRC_BIT   127
`define RQTX_POISON_BIT       79

// -------------------------------------------------------------------------
// Legal keep codes for a non-last beat
// -------------------------------------------------------------------------
`define RQTX_KEEP_1DW         4'h1
`define RQTX_KEEP_2DW         4'h3
`define RQTX_KEEP_3DW         4'h7
`define RQTX_KEEP_4DW         4'hF

// -------------------------------------------------------------------------
// Credit class selection codes
// -------------------------------------------------------------------------
`define RQTX_SEL_AVAILABLE    3'h0
`define RQTX_SEL_PH           3'h1
`define RQTX_SEL_NPH          3'h2
`define RQTX_SEL_CPLH         3'h3
`define RQTX_SEL_PD           3'h4
`define RQTX_SEL_NPD          3'h5
`define RQTX_SEL_CPLD         3'h6

// -------------------------------------------------------------------------
// Reset values
// -------------------------------------------------------------------------
`define RQTX_CREDIT_RESET     12'h000

`endif

// *** rtl/rqtx_adapter.v ***
/*
  Requester request transmit adapter: accepts request beats from the user
  side, checks keep codes, extracts sideband flags and, on a 128-bit bus, descriptor flags, tracks
  per-packet abort, and reports non-posted credits, tag availability and a
  selectable flow control credit class.
  Assumes the link-side logic supplies raw credit counts on MCLK, and that
  the user side sits on MCLK as well, so no synchroniser is needed.
*/
// What this block does
// - Non-last beat keep is contiguous dword mask.
// - Three outputs replace six-bit buffer availability.
// - Report non-posted header credits continuously.
// - Report non-posted payload credits continuously.
// - No configuration transmit request/grant handshake.
// - Selected class credits driven onto outputs.
`timescale 1ns/100ps
`default_nettype none
`include "rqtx_map.vh"

// -------------------------------------------------------------------------
// Design notes
// -------------------------------------------------------------------------
// One register stage sits between user side and link side.
// Ready is combinational, so full rate needs no skid buffer.
// Bad keep codes pass through; the flag lets the link drop them.
// Descriptor flags are latched on a packet's opening beat only.
// Abort closes a packet exactly as a last beat does.
// Credit outputs lag their raw inputs by one cycle.
// Only the ready/valid pair arbitrates; no grant exists.

module rqtx_adapter #(
  parameter DATA_W   = 128,                 // Request data width, 64 or 128
  parameter KEEP_W   = DATA_W / 32,         // One keep bit per dword
  parameter HCRED_W  = 8,                   // Header credit width
  parameter DCRED_W  = 12                   // Data credit width
) (
  // Clock and reset
  input  wire                         MCLK,
  input  wire                         RST_N,
  // Request beats from the user side
  input  wire [DATA_W-1:0]            REQUEST_DATA,
  input  wire [KEEP_W-1:0]            REQUEST_DWORD_KEEP,
  input  wire [`RQTX_SIDEBAND_W-1:0]  REQUEST_SIDEBAND,
  input  wire                         REQUEST_LAST,
  input  wire                         REQUEST_VALID,
  output wire                         REQUEST_READY,
  // Beat towards the link side
  input  wire                         LINK_READY,
  output reg  [DATA_W-1:0]            LINK_DATA,
  output reg                          LINK_VALID,
  output reg                          LINK_LAST,
  output reg  [3:0]                   LINK_FIRST_DWORD_BYTE_ENABLE,
  output reg  [3:0]                   LINK_LAST_DWORD_BYTE_ENABLE,
  output reg  [KEEP_W-1:0]            LINK_DWORD_KEEP,
  output reg                          LINK_FORCE_ECRC,
  output reg                          LINK_POISONED,
  output reg                          LINK_DISCONTINUE,
  output reg                          KEEP_ERROR,
  // Raw credit counts from the link side
  input  wire [HCRED_W-1:0]           RAW_NPH_CREDIT,
  input  wire [DCRED_W-1:0]           RAW_NPD_CREDIT,
  input  wire                         RAW_TAG_FREE,
  input  wire [HCRED_W-1:0]           RAW_PH_CREDIT,
  input  wire [DCRED_W-1:0]           RAW_PD_CREDIT,
  input  wire [HCRED_W-1:0]           RAW_CPLH_CREDIT,
  input  wire [DCRED_W-1:0]           RAW_CPLD_CREDIT,
  // Credit class selection and reports
  input  wire [2:0]                   FLOW_CONTROL_SELECT,
  output reg  [HCRED_W-1:0]           NONPOSTED_HEADER_CREDIT_AVAIL,
  output reg  [DCRED_W-1:0]           NONPOSTED_PAYLOAD_CREDIT_AVAIL,
  output reg                          REQUEST_TAG_AVAIL,
  output reg  [HCRED_W-1:0]           FLOW_CONTROL_HEADER_CREDIT,
  output reg  [DCRED_W-1:0]           FLOW_CONTROL_DATA_CREDIT
);

  // -----------------------------------------------------------------------
  // Beat handshake
  // -----------------------------------------------------------------------
  wire beat_take;                           // Beat accepted this cycle
  wire out_free;                            // Output stage may load
  reg  in_packet_reg;                       // Between first and last beat
  reg  in_packet_next;                      // Next packet state
  reg  keep_ok;                             // Keep code legal for beat

  // Output stage empties when link takes it
  assign out_free      = ~LINK_VALID | LINK_READY;
  assign REQUEST_READY = out_free;
  assign beat_take     = REQUEST_VALID & out_free;

  // Keep check: non-last beats need contiguous low dwords
  always @* begin
    // Last beat may end on any dword
    keep_ok = 1'b1;
    if (!REQUEST_LAST) begin
      if (KEEP_W == 2) begin
        // 64-bit bus: one or two dwords
        keep_ok = (REQUEST_DWORD_KEEP == `RQTX_KEEP_1DW) ||
                  (REQUEST_DWORD_KEEP == `RQTX_KEEP_2DW);
      end else begin
        // 128-bit bus: one to four low dwords
        keep_ok = (REQUEST_DWORD_KEEP == `RQTX_KEEP_1DW) ||
                  (REQUEST_DWORD_KEEP == `RQTX_KEEP_2DW) ||
                  (REQUEST_DWORD_KEEP == `RQTX_KEEP_3DW) ||
                  (REQUEST_DWORD_KEEP == `RQTX_KEEP_4DW);
      end
    end
  end

  // Packet tracking: discontinue ends the packet as last does
  always @* begin
    in_packet_next = in_packet_reg;
    if (beat_take) begin
      if (REQUEST_LAST || REQUEST_SIDEBAND[`RQTX_DISCONTINUE_BIT]) begin
        // Last beat or abort closes it
        in_packet_next = 1'b0;
      end else begin
        // Packet stays open
        in_packet_next = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Output stage registers
  // -----------------------------------------------------------------------
  // Loads one beat, holds it until the link takes it
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      // Idle link side, no packet open
      in_packet_reg                <= 1'b0;
      LINK_DATA                    <= {DATA_W{1'b0}};
      LINK_VALID                   <= 1'b0;
      LINK_LAST                    <= 1'b0;
      LINK_FIRST_DWORD_BYTE_ENABLE <= 4'h0;
      LINK_LAST_DWORD_BYTE_ENABLE  <= 4'h0;
      LINK_DWORD_KEEP              <= {KEEP_W{1'b0}};
      LINK_FORCE_ECRC              <= 1'b0;
      LINK_POISONED                <= 1'b0;
      LINK_DISCONTINUE             <= 1'b0;
      KEEP_ERROR                   <= 1'b0;
    end else begin
      in_packet_reg <= in_packet_next;
      // Valid follows request while stage is free
      if (out_free) begin
        LINK_VALID <= REQUEST_VALID;
      end
      // Fields load only on a taken beat
      if (beat_take) begin
        LINK_DATA       <= REQUEST_DATA;
        LINK_LAST       <= REQUEST_LAST;
        LINK_DWORD_KEEP <= REQUEST_DWORD_KEEP;
        LINK_FIRST_DWORD_BYTE_ENABLE <=
          REQUEST_SIDEBAND[`RQTX_FIRST_DWORD_BYTE_ENABLE_MSB:`RQTX_FIRST_DWORD_BYTE_ENABLE_LSB];
        LINK_LAST_DWORD_BYTE_ENABLE  <=
          REQUEST_SIDEBAND[`RQTX_LAST_DWORD_BYTE_ENABLE_MSB:`RQTX_LAST_DWORD_BYTE_ENABLE_LSB];
        LINK_DISCONTINUE <= REQUEST_SIDEBAND[`RQTX_DISCONTINUE_BIT];
        KEEP_ERROR       <= ~keep_ok;
        // Descriptor flags only on the first beat of a packet
        if (!in_packet_reg && DATA_W > `RQTX_FORCE_ECRC_BIT) begin
          LINK_FORCE_ECRC <= REQUEST_DATA[`RQTX_FORCE_ECRC_BIT % DATA_W];
          LINK_POISONED   <= REQUEST_DATA[`RQTX_POISON_BIT % DATA_W];
        end else if (!in_packet_reg) begin
          LINK_FORCE_ECRC <= 1'b0;          // Narrow bus: descriptor spans beats
          LINK_POISONED   <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Credit reporting
  // -----------------------------------------------------------------------
  // Registered copies of raw credits, refreshed every cycle
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      // No credit reported during reset
      NONPOSTED_HEADER_CREDIT_AVAIL  <= {HCRED_W{1'b0}};
      NONPOSTED_PAYLOAD_CREDIT_AVAIL <= {DCRED_W{1'b0}};
      REQUEST_TAG_AVAIL              <= 1'b0;
    end else begin
      NONPOSTED_HEADER_CREDIT_AVAIL  <= RAW_NPH_CREDIT;
      NONPOSTED_PAYLOAD_CREDIT_AVAIL <= RAW_NPD_CREDIT;
      REQUEST_TAG_AVAIL              <= RAW_TAG_FREE;
    end
  end

  // Class selection for the flow control outputs
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      // Both class outputs start empty
      FLOW_CONTROL_HEADER_CREDIT <= {HCRED_W{1'b0}};
      FLOW_CONTROL_DATA_CREDIT   <= {DCRED_W{1'b0}};
    end else begin
      case (FLOW_CONTROL_SELECT)
        // Posted class
        `RQTX_SEL_PH, `RQTX_SEL_PD: begin
          FLOW_CONTROL_HEADER_CREDIT <= RAW_PH_CREDIT;
          FLOW_CONTROL_DATA_CREDIT   <= RAW_PD_CREDIT;
        end
        // Non-posted class
        `RQTX_SEL_NPH, `RQTX_SEL_NPD: begin
          FLOW_CONTROL_HEADER_CREDIT <= RAW_NPH_CREDIT;
          FLOW_CONTROL_DATA_CREDIT   <= RAW_NPD_CREDIT;
        end
        // Completion class
        `RQTX_SEL_CPLH, `RQTX_SEL_CPLD: begin
          FLOW_CONTROL_HEADER_CREDIT <= RAW_CPLH_CREDIT;
          FLOW_CONTROL_DATA_CREDIT   <= RAW_CPLD_CREDIT;
        end
        // Unused codes fall back to non-posted
        default: begin
          FLOW_CONTROL_HEADER_CREDIT <= RAW_NPH_CREDIT;
          FLOW_CONTROL_DATA_CREDIT   <= RAW_NPD_CREDIT;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** bench/rqtx_asserts.sv ***
/* Port checker for rqtx_adapter: beat transfer, flags and credit outputs.
   Assumes it is bound onto each adapter instance, all on MCLK. */
`timescale 1ns/100ps
`default_nettype none
module rqtx_asserts #(
  parameter DATA_W  = 128,
  parameter HCRED_W = 8,
  parameter DCRED_W = 12
) (
  input wire logic                 MCLK,
  input wire logic                 RST_N,
  input wire logic                 REQUEST_VALID,
  input wire logic                 REQUEST_READY,
  input wire logic                 REQUEST_LAST,
  input wire logic                 LINK_READY,
  input wire logic                 LINK_VALID,
  input wire logic                 LINK_LAST,
  input wire logic                 LINK_FORCE_ECRC,
  input wire logic                 LINK_POISONED,
  input wire logic                 LINK_DISCONTINUE,
  input wire logic                 KEEP_ERROR,
  input wire logic                 RAW_TAG_FREE,
  input wire logic                 REQUEST_TAG_AVAIL,
  input wire logic [DATA_W-1:0]    REQUEST_DATA,
  input wire logic [DATA_W-1:0]    LINK_DATA,
  input wire logic [DATA_W/32-1:0] REQUEST_DWORD_KEEP,
  input wire logic [59:0]          REQUEST_SIDEBAND,
  input wire logic [3:0]           LINK_FIRST_DWORD_BYTE_ENABLE,
  input wire logic [3:0]           LINK_LAST_DWORD_BYTE_ENABLE,
  input wire logic [2:0]           FLOW_CONTROL_SELECT,
  input wire logic [HCRED_W-1:0]   RAW_NPH_CREDIT,
  input wire logic [HCRED_W-1:0]   RAW_PH_CREDIT,
  input wire logic [HCRED_W-1:0]   RAW_CPLH_CREDIT,
  input wire logic [HCRED_W-1:0]   NONPOSTED_HEADER_CREDIT_AVAIL,
  input wire logic [HCRED_W-1:0]   FLOW_CONTROL_HEADER_CREDIT,
  input wire logic [DCRED_W-1:0]   RAW_NPD_CREDIT,
  input wire logic [DCRED_W-1:0]   RAW_PD_CREDIT,
  input wire logic [DCRED_W-1:0]   RAW_CPLD_CREDIT,
  input wire logic [DCRED_W-1:0]   NONPOSTED_PAYLOAD_CREDIT_AVAIL,
  input wire logic [DCRED_W-1:0]   FLOW_CONTROL_DATA_CREDIT
);
  logic first_reg;  // Next taken beat opens a packet
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N) first_reg <= 1'b1;
    else if (REQUEST_VALID && REQUEST_READY) first_reg <= REQUEST_LAST | REQUEST_SIDEBAND[11];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_take; REQUEST_VALID && REQUEST_READY; endsequence
  sequence s_run; $past(RST_N); endsequence
  np_avail_a:
    assert property (s_run |-> {REQUEST_TAG_AVAIL, NONPOSTED_HEADER_CREDIT_AVAIL,
      NONPOSTED_PAYLOAD_CREDIT_AVAIL} == $past({RAW_TAG_FREE, RAW_NPH_CREDIT, RAW_NPD_CREDIT}))
      else $error("np credit wrong");
  fc_post_a:
    assert property (s_run ##0 ($past(FLOW_CONTROL_SELECT) inside {3'h1, 3'h4}) |->
      {FLOW_CONTROL_HEADER_CREDIT, FLOW_CONTROL_DATA_CREDIT} ==
      $past({RAW_PH_CREDIT, RAW_PD_CREDIT})) else $error("posted credit wrong");
  fc_cpl_a:
    assert property (s_run ##0 ($past(FLOW_CONTROL_SELECT) inside {3'h3, 3'h6}) |->
      FLOW_CONTROL_HEADER_CREDIT == $past(RAW_CPLH_CREDIT) && FLOW_CONTROL_DATA_CREDIT ==
      $past(RAW_CPLD_CREDIT)) else $error("completion credit wrong");
  fc_np_a:
    assert property (s_run ##0 ($past(FLOW_CONTROL_SELECT) inside {3'h0, 3'h2, 3'h5, 3'h7}) |->
      FLOW_CONTROL_DATA_CREDIT == $past(RAW_NPD_CREDIT)) else $error("np data credit wrong");
  beat_pass_a:
    assert property (s_take |=> LINK_VALID && LINK_LAST == $past(REQUEST_LAST) &&
      {LINK_LAST_DWORD_BYTE_ENABLE, LINK_FIRST_DWORD_BYTE_ENABLE} == $past(REQUEST_SIDEBAND[7:0]))
      else $error("beat fields wrong");
  abort_pass_a:
    assert property (s_take |=> LINK_DISCONTINUE == $past(REQUEST_SIDEBAND[11]))
      else $error("discontinue wrong");
  keep_flag_a:
    assert property (s_take |=> KEEP_ERROR == !($past(REQUEST_LAST) ||
      ($past(REQUEST_DWORD_KEEP) inside {1, 3, 7, 15}))) else $error("keep flag wrong");
  desc_flags_a:
    assert property (s_take ##0 first_reg |=> {LINK_FORCE_ECRC, LINK_POISONED} ==
      $past({REQUEST_DATA[127], REQUEST_DATA[79]})) else $error("descriptor flags wrong");
  stall_hold_a:
    assert property (LINK_VALID && !LINK_READY |-> !REQUEST_READY ##1 LINK_VALID &&
      $stable(LINK_DATA)) else $error("stalled beat lost");
endmodule
bind rqtx_adapter rqtx_asserts #(.DATA_W(DATA_W), .HCRED_W(HCRED_W), .DCRED_W(DCRED_W))
  rqtx_asserts_inst (.*);
`default_nettype wire

// *** bench/rqtx_user_model.sv ***
/* Behavioural user side issuing request beats, at random pace.
   Assumes the adapter's ready and credit outputs on MCLK. */
`timescale 1ns/100ps
`default_nettype none
module rqtx_user_model (
  input  wire logic         MCLK,
  input  wire logic         RST_N,
  input  wire logic         REQUEST_READY,
  input  wire logic         REQUEST_TAG_AVAIL,
  input  wire logic         ALLOW_BAD_KEEP,
  input  wire logic [7:0]   NONPOSTED_HEADER_CREDIT_AVAIL,
  input  wire logic [11:0]  NONPOSTED_PAYLOAD_CREDIT_AVAIL,
  output logic      [127:0] REQUEST_DATA = 128'h0,
  output logic      [59:0]  REQUEST_SIDEBAND = 60'h0,
  output logic      [3:0]   REQUEST_DWORD_KEEP = 4'h0,
  output logic              REQUEST_LAST = 1'b0,
  output logic              REQUEST_VALID = 1'b0
);
  integer seed = 37;
  logic take = 1'b0;  // Beat taken at the coming edge
  logic [3:0] k [8] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'hF, 4'h2, 4'h5, 4'h0};  // Last three illegal
  always @(negedge MCLK) take = REQUEST_VALID && REQUEST_READY;
  always @(posedge MCLK) begin
    #1;
    if (!RST_N) REQUEST_VALID = 1'b0;
    else if (take || !REQUEST_VALID) begin  // Unaccepted beats stay untouched
      REQUEST_VALID = $random(seed) % 4 != 0 && REQUEST_TAG_AVAIL &&
        NONPOSTED_HEADER_CREDIT_AVAIL != 8'h00 && NONPOSTED_PAYLOAD_CREDIT_AVAIL != 12'h000;
      REQUEST_DATA = {$random(seed), $random(seed), $random(seed), $random(seed)};
      REQUEST_SIDEBAND = 60'({$random(seed), $random(seed)});
      REQUEST_DWORD_KEEP = k[3'($random(seed)) & (ALLOW_BAD_KEEP ? 3'h7 : 3'h3)];
      REQUEST_LAST = $random(seed) % 3 == 0;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_requester_request_tx_adapter.sv ***
/* Self-checking bench: random beats, stalls, credit classes.
   Assumes rqtx_adapter with default widths and the user model. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module tb_requester_request_tx_adapter;
  logic MCLK = 1'b0, RST_N = 1'b0, LINK_READY = 1'b0, RAW_TAG_FREE = 1'b0, ALLOW_BAD_KEEP = 1'b0;
  logic [2:0] FLOW_CONTROL_SELECT = 3'h0;
  logic [7:0] RAW_NPH_CREDIT = 8'h00, RAW_PH_CREDIT = 8'h00, RAW_CPLH_CREDIT = 8'h00;
  logic [11:0] RAW_NPD_CREDIT = 12'h000, RAW_PD_CREDIT = 12'h000, RAW_CPLD_CREDIT = 12'h000;
  logic [127:0] REQUEST_DATA, LINK_DATA;
  logic [59:0] REQUEST_SIDEBAND;
  logic [3:0] REQUEST_DWORD_KEEP, LINK_DWORD_KEEP, LINK_FIRST_DWORD_BYTE_ENABLE;
  logic [3:0] LINK_LAST_DWORD_BYTE_ENABLE;
  logic REQUEST_LAST, REQUEST_VALID, REQUEST_READY, LINK_VALID, LINK_LAST, LINK_FORCE_ECRC;
  logic LINK_POISONED, LINK_DISCONTINUE, KEEP_ERROR, REQUEST_TAG_AVAIL;
  logic [7:0] NONPOSTED_HEADER_CREDIT_AVAIL, FLOW_CONTROL_HEADER_CREDIT;
  logic [11:0] NONPOSTED_PAYLOAD_CREDIT_AVAIL, FLOW_CONTROL_DATA_CREDIT;
  integer seed = 37, n_cyc = 0, n_run = 0, checks = 0, n_fail = 0;
  logic [63:0] prev;         // Select and raw credits one cycle back
  logic [144:0] q [$];       // Expected link beats
  logic [1:0] flags;         // Descriptor flags of the open packet
  logic first = 1'b1;        // Next beat opens a packet
  logic [20:0] seen_np;      // Observed non-posted reports
  logic [19:0] seen_fc;      // Observed class reports
  logic [144:0] exp_beat;    // Front of the expected queue
  logic [144:0] seen_beat;   // Beat shown on the link side
  rqtx_adapter rqtx_adapter_inst (.*);
  rqtx_user_model rqtx_user_model_inst (.*);
  initial forever #2.5 MCLK = ~MCLK;
  function automatic logic [19:0] exp_fc(input logic [63:0] b);
    case (b[63:61])
      3'h1, 3'h4: return b[39:20];  // Posted class
      3'h3, 3'h6: return b[19:0];   // Completion class
      default: return b[59:40];     // Non-posted class
    endcase
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Settled samples at the falling edge
  always @(negedge MCLK) if (RST_N) begin
    n_run++;
    seen_np = {REQUEST_TAG_AVAIL, NONPOSTED_HEADER_CREDIT_AVAIL,
      NONPOSTED_PAYLOAD_CREDIT_AVAIL};
    seen_fc = {FLOW_CONTROL_HEADER_CREDIT, FLOW_CONTROL_DATA_CREDIT};
    if (n_run > 1) begin
      `CHK("np credit", prev[60:40], seen_np)
      `CHK("fc credit", exp_fc(prev), seen_fc)
    end
    prev = {FLOW_CONTROL_SELECT, RAW_TAG_FREE, RAW_NPH_CREDIT, RAW_NPD_CREDIT, RAW_PH_CREDIT,
      RAW_PD_CREDIT, RAW_CPLH_CREDIT, RAW_CPLD_CREDIT};
    if (LINK_VALID && LINK_READY) begin
      // Pop once, so a mismatch does not shift the queue
      exp_beat = q.pop_front();
      seen_beat = {LINK_DATA, LINK_LAST_DWORD_BYTE_ENABLE, LINK_FIRST_DWORD_BYTE_ENABLE,
        LINK_DISCONTINUE, LINK_LAST, LINK_DWORD_KEEP, KEEP_ERROR, LINK_FORCE_ECRC,
        LINK_POISONED};
      `CHK("link beat", exp_beat, seen_beat)
    end
    if (REQUEST_VALID && REQUEST_READY) begin
      if (first) flags = {REQUEST_DATA[127], REQUEST_DATA[79]};
      q.push_back({REQUEST_DATA, REQUEST_SIDEBAND[7:0], REQUEST_SIDEBAND[11], REQUEST_LAST,
        REQUEST_DWORD_KEEP, !REQUEST_LAST && !(REQUEST_DWORD_KEEP inside {4'h1, 4'h3, 4'h7, 4'hF}),
        flags});
      first = REQUEST_LAST | REQUEST_SIDEBAND[11];
    end
  end
  // Hang guard
  always @(posedge MCLK) begin
    n_cyc++;
    if (n_cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  // Stalls, credit droughts and every select code
  initial begin
    repeat (8) @(posedge MCLK);
    #1 RST_N = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge MCLK);
      #1;
      LINK_READY = (i % 400 < 100) ? 1'b1 : (i % 400 < 130) ? 1'b0 : ($random(seed) % 2 != 0);
      ALLOW_BAD_KEEP = i >= 1500;
      FLOW_CONTROL_SELECT = 3'(i / 3);
      RAW_NPH_CREDIT = (i % 300 < 20) ? 8'h00 : 8'($random(seed));
      RAW_NPD_CREDIT = (i % 300 > 280) ? 12'h000 : 12'($random(seed));
      RAW_TAG_FREE = $random(seed) % 8 != 0;
      {RAW_PH_CREDIT, RAW_PD_CREDIT, RAW_CPLH_CREDIT, RAW_CPLD_CREDIT} =
        40'({$random(seed), $random(seed)});
    end
    end_sim();
  end
endmodule
`default_nettype wire
